/* hw/brownout_gate.sv */
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------------------
// one supply's brownout reset gate
// ------------------------------------------------------------
module brownout_gate (
  input wire logic clock,
  input wire logic rst,
  input wire logic brownout_pin,
  input wire logic reset_disable,
  output logic brownout_reset
);
  typedef struct packed {
    logic meta;
    logic sync;
    logic rst_out;
  } gate_s;
  gate_s st_ff;
  gate_s nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.meta = brownout_pin;
    nxt_st.sync = st_ff.meta;
    // disable bit set suppresses the reset
    nxt_st.rst_out = st_ff.sync & ~reset_disable;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign brownout_reset = st_ff.rst_out;
endmodule // brownout_gate
`default_nettype wire

/* hw/hw_config_brownout_portsel.sv */
`timescale 1ns/100ps
`default_nettype none
module hw_config_brownout_portsel (
  input wire logic clock,
  input wire logic rst,
  input wire logic [2:0] op_mode,
  input wire logic [7:0] nv_byte,
  input wire logic prog_wr,
  input wire logic [7:0] prog_addr,
  input wire logic [7:0] prog_wdata,
  output logic [7:0] prog_rdata,
  input wire logic addr_sel_wr,
  input wire logic [7:0] addr_sel_wdata,
  output logic [7:0] config_data_window,
  output logic [7:0] config_address_select,
  output logic nv_wr,
  output logic [7:0] nv_wdata,
  input wire logic dvdd_brownout,
  input wire logic avdd_brownout,
  output logic [1:0] digital_brownout_level,
  output logic [1:0] analog_brownout_level,
  output logic digital_brownout_reset,
  output logic analog_brownout_reset,
  output logic port0_ext_bus,
  output logic port2_ext_bus,
  output logic p3_strobes_en
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic loaded;
    logic [7:0] cfg;
    logic [7:0] addr_sel;
    logic [7:0] rdata;
    logic wr;
    logic [7:0] wdata;
  } cfg_s;
  cfg_s st_ff;
  cfg_s nxt_st;
  logic prog_mode;
  logic hit;

  assign prog_mode = (op_mode == hwcfg_pkg::MODE_SERIAL_PROG) ||
                     (op_mode == hwcfg_pkg::MODE_PARALLEL_PROG);
  assign hit = (prog_addr == hwcfg_pkg::CFG_ADDR_BYTE_ONE);

  // ------------------------------------------------------------
  // load, program and read-back
  // ------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.wr = 1'b0;
    // strap the stored byte once after reset; settings then hold
    if (!st_ff.loaded) begin
      nxt_st.cfg = nv_byte;
      nxt_st.loaded = 1'b1;
    end
    // new value goes to flash only; takes effect at next reset
    if (prog_wr && hit && prog_mode) begin
      nxt_st.wr = 1'b1;
      nxt_st.wdata = prog_wdata;
    end
    if (addr_sel_wr) begin
      nxt_st.addr_sel = addr_sel_wdata;
    end
    // data window shows the byte only when it is addressed
    if (st_ff.addr_sel == hwcfg_pkg::CFG_ADDR_BYTE_ONE) begin
      nxt_st.rdata = st_ff.cfg;
    end else begin
      nxt_st.rdata = 8'h00;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      st_ff.loaded <= 1'b0;
      st_ff.cfg <= hwcfg_pkg::CFG_RESET;
      st_ff.addr_sel <= hwcfg_pkg::ADDR_SEL_RESET;
      st_ff.rdata <= 8'h00;
      st_ff.wr <= 1'b0;
      st_ff.wdata <= 8'h00;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign config_data_window = st_ff.rdata;
  assign prog_rdata = st_ff.rdata;
  assign config_address_select = st_ff.addr_sel;
  assign nv_wr = st_ff.wr;
  assign nv_wdata = st_ff.wdata;

  // ------------------------------------------------------------
  // decoded settings
  // ------------------------------------------------------------
  assign digital_brownout_level =
    st_ff.cfg[hwcfg_pkg::DIG_LVL_HI:hwcfg_pkg::DIG_LVL_LO];
  assign analog_brownout_level =
    st_ff.cfg[hwcfg_pkg::ANA_LVL_HI:hwcfg_pkg::ANA_LVL_LO];
  assign port0_ext_bus = ~st_ff.cfg[hwcfg_pkg::PORT0_GPIO_BIT];
  assign port2_ext_bus = ~st_ff.cfg[hwcfg_pkg::PORT23_GPIO_BIT];
  assign p3_strobes_en = port0_ext_bus | port2_ext_bus;

  brownout_gate u_dig_gate (
    .clock(clock),
    .rst(rst),
    .brownout_pin(dvdd_brownout),
    .reset_disable(st_ff.cfg[hwcfg_pkg::DIG_RST_DIS_BIT]),
    .brownout_reset(digital_brownout_reset)
  );

  brownout_gate u_ana_gate (
    .clock(clock),
    .rst(rst),
    .brownout_pin(avdd_brownout),
    .reset_disable(st_ff.cfg[hwcfg_pkg::ANA_RST_DIS_BIT]),
    .brownout_reset(analog_brownout_reset)
  );
endmodule // hw_config_brownout_portsel
`default_nettype wire

/* hw/hwcfg_pkg.sv */
package hwcfg_pkg;
  // ------------------------------------------------------------
  // configuration space
  // ------------------------------------------------------------
  localparam logic [7:0] CFG_ADDR_BYTE_ONE = 8'h7E;
  localparam logic [7:0] CFG_BLANK = 8'hFF;
  localparam logic [7:0] CFG_RESET = 8'hFF;
  localparam logic [7:0] ADDR_SEL_RESET = 8'h00;
  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int DIG_LVL_HI = 7;
  localparam int DIG_LVL_LO = 6;
  localparam int ANA_LVL_HI = 5;
  localparam int ANA_LVL_LO = 4;
  localparam int ANA_RST_DIS_BIT = 3;
  localparam int DIG_RST_DIS_BIT = 2;
  localparam int PORT0_GPIO_BIT = 1;
  localparam int PORT23_GPIO_BIT = 0;
  // ------------------------------------------------------------
  // brownout level codes
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    LVL_4V5 = 2'h0,
    LVL_4V2 = 2'h1,
    LVL_2V7 = 2'h2,
    LVL_2V5 = 2'h3
  } brownout_level_e;
  // ------------------------------------------------------------
  // operating modes
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_USER = 3'h1,
    MODE_SERIAL_PROG = 3'h2,
    MODE_PARALLEL_PROG = 3'h4
  } op_mode_e;
endpackage

/* test/hwcfg_props.sv */
`timescale 1ns/100ps
`default_nettype none
// ----------------
// config byte checks
// ----------------
module hwcfg_props (
  input wire logic clock,
  input wire logic rst,
  input wire logic [2:0] op_mode,
  input wire logic prog_wr,
  input wire logic [7:0] prog_addr,
  input wire logic [7:0] prog_wdata,
  input wire logic addr_sel_wr,
  input wire logic [7:0] addr_sel_wdata,
  input wire logic [7:0] config_data_window,
  input wire logic [7:0] config_address_select,
  input wire logic nv_wr,
  input wire logic [7:0] nv_wdata,
  input wire logic dvdd_brownout,
  input wire logic [1:0] digital_brownout_level,
  input wire logic digital_brownout_reset,
  input wire logic port0_ext_bus,
  input wire logic port2_ext_bus,
  input wire logic p3_strobes_en
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  wire take = prog_wr && prog_addr == 8'h7E && op_mode inside {3'h2, 3'h4};
  wire sel7e = config_address_select == 8'h7E;
  sequence rd_s;
    addr_sel_wr && addr_sel_wdata == 8'h7E ##1 sel7e;
  endsequence
  AST_NV_TAKE: assert property (take |=> nv_wr && nv_wdata == $past(prog_wdata))
    else $error("write lost");
  AST_NV_REFUSE: assert property (!take |=> !nv_wr)
    else $error("write leaked");
  AST_ADDR_SEL: assert property (addr_sel_wr |=>
    config_address_select == $past(addr_sel_wdata)) else $error("select");
  AST_WIN_OTHER: assert property (!sel7e |=> config_data_window == 8'h00)
    else $error("window not clear");
  AST_WIN_CFG: assert property (rd_s |=> config_data_window[7:6] == digital_brownout_level
    && config_data_window[1:0] == ~{port0_ext_bus, port2_ext_bus}) else $error("window");
  AST_STROBES: assert property (p3_strobes_en == (port0_ext_bus || port2_ext_bus))
    else $error("strobes");
  // settings load once, one edge after release
  AST_CFG_HOLD: assert property (!$past(rst) && !$past(rst, 2) |->
    $stable({digital_brownout_level, port0_ext_bus, port2_ext_bus})) else $error("cfg moved");
  AST_DIG_RST: assert property (digital_brownout_reset |-> $past(dvdd_brownout, 3))
    else $error("brownout reset");
endmodule // hwcfg_props
bind hw_config_brownout_portsel hwcfg_props u_hwcfg_props (.*);
`default_nettype wire

/* test/nv_flash_model.sv */
`timescale 1ns/100ps
`default_nettype none
module nv_flash_model (
  input wire logic clock,
  input wire logic nv_wr,
  input wire logic [7:0] nv_wdata,
  output logic [7:0] nv_byte
);
  initial nv_byte = 8'hFF;
  // cell survives device resets, unlike the device copy
  always @(posedge clock) begin
    if (nv_wr) nv_byte <= nv_wdata;
  end
endmodule // nv_flash_model
`default_nettype wire

/* test/tb.sv */
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic clock = 0, rst = 1, prog_wr = 0, addr_sel_wr = 0, dvdd_brownout = 0, avdd_brownout = 0;
  logic [2:0] op_mode = 3'h1;
  logic [7:0] prog_addr = 8'h00, prog_wdata = 8'h00, addr_sel_wdata = 8'h00, d, p;
  logic [7:0] prog_rdata, config_data_window, config_address_select, nv_wdata, nv_byte;
  logic nv_wr, digital_brownout_reset, analog_brownout_reset, port0_ext_bus, port2_ext_bus;
  logic p3_strobes_en;
  logic [1:0] digital_brownout_level, analog_brownout_level;
  logic [31:0] seed = 32'd96434;
  int n_mismatch = 0, check_count = 0, cycles = 0;
  always #2 clock = ~clock;
  hw_config_brownout_portsel u_hw_config_brownout_portsel (.*);
  nv_flash_model u_nv_flash_model (.*);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] view(input logic [7:0] c);
    return {c[7:4], ~c[1], ~c[0], ~(c[1] & c[0]), 1'b0};
  endfunction
  function automatic logic [7:0] outs();
    return {digital_brownout_level, analog_brownout_level, port0_ext_bus, port2_ext_bus,
      p3_strobes_en, 1'b0};
  endfunction
  task automatic chk(input string nm, input logic [7:0] exp, got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic wrap_up;
    if (n_mismatch == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [2:0] m, input logic [7:0] a, v);
    op_mode = m;
    prog_addr = a;
    prog_wdata = v;
    prog_wr = 1;
    @(negedge clock);
  endtask
  task automatic sel(input logic [7:0] a);
    addr_sel_wr = 1;
    addr_sel_wdata = a;
    @(negedge clock);
    addr_sel_wr = 0;
    repeat (2) @(negedge clock);
  endtask
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  initial begin
    p = 8'hFF;
    for (int i = 0; i < 11; i++) begin
      rst = 1;
      repeat (6) @(negedge clock);
      rst = 0;
      repeat (3) @(negedge clock);
      chk("outs", view(p), outs());
      sel(8'h7E);
      chk("window", p, config_data_window);
      chk("prog_rdata", p, prog_rdata);
      sel(8'h7D);
      chk("window", 8'h00, config_data_window);
      dvdd_brownout = 1;
      avdd_brownout = 1;
      repeat (5) @(negedge clock);
      chk("dig_rst", {7'h00, ~p[2]}, {7'h00, digital_brownout_reset});
      chk("ana_rst", {7'h00, ~p[3]}, {7'h00, analog_brownout_reset});
      dvdd_brownout = 0;
      avdd_brownout = 0;
      seed = lfsr(seed);
      d = i == 0 ? 8'h00 : seed[7:0];
      // good write first, so a leaked refusal would overwrite it
      wr(i[0] ? 3'h4 : 3'h2, 8'h7E, d);
      wr(3'h1, 8'h7E, ~d);
      wr(3'h2, 8'h7F, ~d);
      wr(3'h6, 8'h7E, ~d);
      prog_wr = 0;
      @(negedge clock);
      chk("flash", d, nv_byte);
      chk("outs", view(p), outs());
      p = d;
    end
    wrap_up();
  end
endmodule // tb
`default_nettype wire
